// ---- hdl/ext_status_interrupt_ctrl.sv ----
`timescale 1ns/100ps
module ext_status_interrupt_ctrl #(
   parameter int ABORT_ONES_P = ext_status_pkg::ABORT_ONES,
   parameter int RX_DEPTH_P = ext_status_pkg::RX_DEPTH
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [ext_status_pkg::ADDR_W-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   input wire logic [ext_status_pkg::ADDR_W-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   input wire logic cts_in,
   input wire logic carrier_detect_in,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_n_out,
   input wire logic brg_zero_in,
   input wire logic rx_bit_valid_in,
   input wire logic rx_bit_in,
   input wire logic rx_null_fe_in,
   input wire logic rx_break_end_in,
   input wire logic sync_pattern_in,
   input wire logic flag_in,
   input wire logic rx_char_in,
   input wire logic rx_char_read_in,
   input wire logic tx_underrun_in,
   input wire logic tx_load_in,
   input wire logic tx_drain_in,
   input wire logic tx_crc_sending_in,
   output logic ext_status_int_out
);
   import ext_status_pkg::*;

   localparam int CNT_W = $clog2(RX_DEPTH_P + 1); // fifo count width
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH_P);
   localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
   localparam logic [3:0] ONES_TOP = 4'(ABORT_ONES_P); // saturate here
   localparam logic [3:0] ONES_LAST = 4'(ABORT_ONES_P - 1);

   // ----------------------------------------------------------------
   // bus slave state
   // ----------------------------------------------------------------
   logic aw_q; // write address held
   logic w_q; // write data held
   logic [ADDR_W-1:0] awaddr_q; // held write address
   logic [31:0] wdata_q; // held write data
   logic [3:0] wstrb_q; // held byte enables
   logic bvalid_q; // write answer up
   logic [1:0] bresp_q; // write answer code
   logic rvalid_q; // read answer up
   logic [1:0] rresp_q; // read answer code
   logic [31:0] rdata_q; // read data
   logic wr_do; // write performed this cycle
   logic wr_lane; // low byte lane enabled
   logic wr_map; // write address mapped

   assign awready_out = ~aw_q;
   assign wready_out = ~w_q;
   assign bvalid_out = bvalid_q;
   assign bresp_out = bresp_q;
   assign arready_out = ~rvalid_q;
   assign rvalid_out = rvalid_q;
   assign rresp_out = rresp_q;
   assign rdata_out = rdata_q;
   assign wr_do = aw_q & w_q & ~bvalid_q;
   assign wr_lane = wr_do & wstrb_q[0];
   assign wr_map = (awaddr_q == ADDR_SRC_EN) | (awaddr_q == ADDR_STATUS)
      | (awaddr_q == ADDR_CTRL) | (awaddr_q == ADDR_CMD)
      | (awaddr_q == ADDR_PEND);

   // ----------------------------------------------------------------
   // block state
   // ----------------------------------------------------------------
   logic [7:0] src_en_q; // source enable register
   logic [7:0] ctrl_q; // control register
   mode_type mode; // current mode
   logic [7:0] ie; // enables gated by group
   logic cmd_hit; // command register written
   logic chan_rst; // hardware or channel reset
   logic ext_release; // pending release command
   logic eom_clr; // underrun/eom clear command
   logic send_abort; // send abort command
   logic enter_hunt; // enter hunt command
   logic pend_q; // ext/status pending latch
   logic eom_q; // underrun/eom latch
   logic eom_prev_q; // eom one cycle ago
   logic brk_q; // break/abort condition
   logic [3:0] ones_q; // run of received ones
   logic hunt_q; // hunt condition
   logic txe_q; // transmit buffer empty
   logic [CNT_W-1:0] rx_cnt_q; // receive fifo fill
   logic sync_q; // driven sync pin level
   logic sync_live; // sync/hunt source
   logic sync_ie; // sync/hunt enable after option
   logic brk_st, cts_st, dcd_st, sync_st; // reported bits
   logic brk_ev, cts_ev, dcd_ev, sync_ev; // change events
   logic eom_ev; // eom rising event
   logic zero_st; // zero count bit
   logic zero_ev; // zero count event
   logic any_ev; // any enabled event
   logic [7:0] status; // buffer and line status

   assign mode = mode_type'(ctrl_q[CTL_MODE_LO +: 2]);
   assign ie = src_en_q & {8{ctrl_q[CTL_GROUP_EN]}};
   assign cmd_hit = wr_lane & (awaddr_q == ADDR_CMD);
   assign chan_rst = ~rst_n_in | (cmd_hit & wdata_q[CMD_CHAN_RESET]);
   assign ext_release = cmd_hit & wdata_q[CMD_RESET_EXT];
   assign eom_clr = cmd_hit & wdata_q[CMD_RESET_EOM];
   assign send_abort = cmd_hit & wdata_q[CMD_SEND_ABORT];
   assign enter_hunt = cmd_hit & wdata_q[CMD_ENTER_HUNT];

   // ----------------------------------------------------------------
   // write channel capture
   // ----------------------------------------------------------------
   // address and data taken in either order
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         aw_q <= 1'b0;
         awaddr_q <= '0;
      end else if (wr_do) begin
         aw_q <= 1'b0;
      end else if (awvalid_in && !aw_q) begin
         aw_q <= 1'b1;
         awaddr_q <= awaddr_in;
      end
   end

   // data beat held until the write is done
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         w_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else if (wr_do) begin
         w_q <= 1'b0;
      end else if (wvalid_in && !w_q) begin
         w_q <= 1'b1;
         wdata_q <= wdata_in;
         wstrb_q <= wstrb_in;
      end
   end

   // write answer raised one cycle after both parts held
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bready_in) begin
         bvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   // one read at a time, data registered
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
      end else if (arvalid_in && !rvalid_q) begin
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         unique case (araddr_in)
            ADDR_SRC_EN: rdata_q <= {24'h000000, src_en_q};
            ADDR_STATUS: rdata_q <= {24'h000000, status};
            ADDR_CTRL: rdata_q <= {24'h000000, ctrl_q};
            ADDR_CMD: rdata_q <= '0; // commands read as zero
            ADDR_PEND: rdata_q <= {31'h00000000, pend_q};
            default: begin
               rdata_q <= '0;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (rready_in) begin
         rvalid_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // enables set by any reset except zero count
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         src_en_q <= SRC_EN_RESET;
      end else if (wr_lane && awaddr_q == ADDR_SRC_EN) begin
         src_en_q <= wdata_q[7:0] & SRC_EN_MASK;
      end
   end

   // control survives a channel reset
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         ctrl_q <= CTRL_RESET;
      end else if (wr_lane && awaddr_q == ADDR_CTRL) begin
         ctrl_q <= wdata_q[7:0];
      end
   end

   // ----------------------------------------------------------------
   // transmit underrun/end of message
   // ----------------------------------------------------------------
   // set wins over the clear command
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         eom_q <= 1'b1;
      end else if (!ctrl_q[CTL_TX_EN] || send_abort || tx_underrun_in) begin
         eom_q <= 1'b1;
      end else if (eom_clr) begin
         eom_q <= 1'b0;
      end
   end

   // edge history for the rising event
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         eom_prev_q <= 1'b1;
      end else begin
         eom_prev_q <= eom_q;
      end
   end

   assign eom_ev = ie[BIT_EOM] & eom_q & ~eom_prev_q;

   // ----------------------------------------------------------------
   // break and abort detection
   // ----------------------------------------------------------------
   // run of ones, saturating
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         ones_q <= '0;
      end else if (rx_bit_valid_in) begin
         if (!rx_bit_in) begin
            ones_q <= '0;
         end else if (ones_q != ONES_TOP) begin
            ones_q <= ones_q + 4'h1;
         end
      end
   end

   // break in async, abort in frame mode
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         brk_q <= 1'b0;
      end else begin
         unique case (mode)
            MODE_ASYNC: begin
               if (rx_null_fe_in) begin
                  brk_q <= 1'b1;
               end else if (rx_break_end_in) begin
                  brk_q <= 1'b0;
               end
            end
            MODE_FRAME: begin
               if (rx_bit_valid_in && rx_bit_in && ones_q >= ONES_LAST) begin
                  brk_q <= 1'b1;
               end else if (rx_bit_valid_in && !rx_bit_in) begin
                  brk_q <= 1'b0;
               end
            end
            MODE_BYTE_SYNC, MODE_EXT_SYNC: brk_q <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // hunt and sync pin
   // ----------------------------------------------------------------
   // hunt set by command, cleared by sync or first flag
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         hunt_q <= 1'b1;
      end else if (enter_hunt) begin
         hunt_q <= 1'b1;
      end else if (mode == MODE_FRAME && !ctrl_q[CTL_RX_EN]) begin
         hunt_q <= 1'b1;
      end else if (mode == MODE_BYTE_SYNC && sync_pattern_in) begin
         hunt_q <= 1'b0;
      end else if (mode == MODE_FRAME && flag_in) begin
         hunt_q <= 1'b0;
      end
   end

   // sync pin pulses low per pattern in byte sync
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         sync_q <= 1'b1;
      end else begin
         sync_q <= ~(mode == MODE_BYTE_SYNC && sync_pattern_in);
      end
   end

   assign sync_out = sync_q;
   assign sync_oe_n_out = (mode != MODE_BYTE_SYNC);

   // source of the sync/hunt bit per mode
   always_comb begin
      unique case (mode)
         MODE_ASYNC: sync_live = sync_in & ~ctrl_q[CTL_CRYSTAL_OSCILLATOR_OPTION];
         MODE_EXT_SYNC: sync_live = ~sync_in;
         MODE_BYTE_SYNC, MODE_FRAME: sync_live = hunt_q;
      endcase
   end

   assign sync_ie = ie[BIT_SYNC]
      & ~(mode == MODE_ASYNC && ctrl_q[CTL_CRYSTAL_OSCILLATOR_OPTION]);

   // ----------------------------------------------------------------
   // latched sources
   // ----------------------------------------------------------------
   ext_status_latch u_brk (
      .clk_in(clk_in), .rst_n_in(~chan_rst), .live_in(brk_q),
      .enable_in(ie[BIT_BREAK]), .pending_in(pend_q),
      .status_out(brk_st), .event_out(brk_ev));
   ext_status_latch u_cts (
      .clk_in(clk_in), .rst_n_in(~chan_rst), .live_in(cts_in),
      .enable_in(ie[BIT_CTS]), .pending_in(pend_q),
      .status_out(cts_st), .event_out(cts_ev));
   ext_status_latch u_sync (
      .clk_in(clk_in), .rst_n_in(~chan_rst), .live_in(sync_live),
      .enable_in(sync_ie), .pending_in(pend_q),
      .status_out(sync_st), .event_out(sync_ev));
   ext_status_latch u_dcd (
      .clk_in(clk_in), .rst_n_in(~chan_rst), .live_in(carrier_detect_in),
      .enable_in(ie[BIT_DCD]), .pending_in(pend_q),
      .status_out(dcd_st), .event_out(dcd_ev));

   // zero count never latched, ignored while pending
   assign zero_st = ie[BIT_ZERO] & brg_zero_in;
   assign zero_ev = zero_st & ~pend_q;

   // ----------------------------------------------------------------
   // pending latch
   // ----------------------------------------------------------------
   assign any_ev = brk_ev | eom_ev | cts_ev | sync_ev | dcd_ev | zero_ev;

   // an event in the release cycle keeps it pending
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         pend_q <= 1'b0;
      end else if (any_ev) begin
         pend_q <= 1'b1;
      end else if (ext_release) begin
         pend_q <= 1'b0;
      end
   end

   assign ext_status_int_out = pend_q;

   // ----------------------------------------------------------------
   // buffer status
   // ----------------------------------------------------------------
   // load after drain leaves the buffer full
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         txe_q <= 1'b1;
      end else if (tx_load_in) begin
         txe_q <= 1'b0;
      end else if (tx_drain_in) begin
         txe_q <= 1'b1;
      end
   end

   // receive fill count, emptied by reset
   always_ff @(posedge clk_in) begin
      if (chan_rst) begin
         rx_cnt_q <= '0;
      end else begin
         unique case ({rx_char_in && rx_cnt_q != CNT_FULL,
                       rx_char_read_in && rx_cnt_q != '0})
            2'b10: rx_cnt_q <= rx_cnt_q + CNT_ONE;
            2'b01: rx_cnt_q <= rx_cnt_q - CNT_ONE;
            2'b00, 2'b11: rx_cnt_q <= rx_cnt_q;
         endcase
      end
   end

   assign status = {brk_st, eom_q, cts_st, sync_st, dcd_st,
      txe_q & ~tx_crc_sending_in, zero_st, rx_cnt_q != '0};

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   a_group_gate: assert property (
      (!ctrl_q[CTL_GROUP_EN] && !pend_q) |=> !pend_q)
      else $error("pending without group enable");
   a_reset_enables: assert property (
      chan_rst |=> src_en_q == SRC_EN_RESET)
      else $error("enables not restored by reset");
   // a cleared latch set again by send abort must also interrupt
   a_eom_abort: assert property (
      (send_abort && !eom_q && ie[BIT_EOM] && !chan_rst)
      |=> eom_q ##1 pend_q) else $error("send abort did not interrupt");
   a_eom_hold: assert property (
      (eom_q && !eom_clr) |=> eom_q)
      else $error("eom cleared without command");
   a_break_set: assert property (
      (mode == MODE_ASYNC && rx_null_fe_in && !chan_rst) |=> brk_q)
      else $error("break not set");
   a_abort_end: assert property (
      (mode == MODE_FRAME && rx_bit_valid_in && !rx_bit_in) |=> !brk_q)
      else $error("abort not ended");
   a_crystal_oscillator_option_force: assert property (
      (mode == MODE_ASYNC && ctrl_q[CTL_CRYSTAL_OSCILLATOR_OPTION])
      |-> !status[BIT_SYNC] && !sync_ev) else $error("sync not forced");
   a_ext_sync: assert property (
      (mode == MODE_EXT_SYNC && sync_in) |-> !sync_live)
      else $error("hunt not held clear");
   // enter hunt in the same cycle wins over the found pattern
   a_sync_pulse: assert property (
      (mode == MODE_BYTE_SYNC && sync_pattern_in && !enter_hunt
      && !chan_rst) |=> !sync_out && !hunt_q) else $error("no sync pulse");
   a_txe_load: assert property (
      (tx_load_in && !chan_rst) |=> !status[BIT_TXE])
      else $error("buffer empty after load");
   a_zero_int: assert property (
      (zero_st && !pend_q && !chan_rst) |=> pend_q)
      else $error("zero count did not interrupt");
   a_fifo_reset: assert property (
      chan_rst |=> !status[BIT_RXA]) else $error("fifo not emptied");

   c_cts_int: cover property (!pend_q ##1 cts_ev ##1 pend_q);
   c_release: cover property (pend_q && ext_release ##1 !pend_q);
   c_abort: cover property (mode == MODE_FRAME && $rose(brk_q));
endmodule : ext_status_interrupt_ctrl

// ---- hdl/ext_status_pkg.sv ----
package ext_status_pkg;
   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5; // byte address bits decoded
   localparam logic [1:0] RESP_OKAY = 2'h0; // normal answer
   localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_SRC_EN = 5'h00; // source enables
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04; // buffer/line stat
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h08; // group/mode ctrl
   localparam logic [ADDR_W-1:0] ADDR_CMD = 5'h0c; // command pulses
   localparam logic [ADDR_W-1:0] ADDR_PEND = 5'h10; // pending flag
   // ----------------------------------------------------------------
   // status and enable bit positions
   // ----------------------------------------------------------------
   localparam int BIT_BREAK = 7; // break/abort
   localparam int BIT_EOM = 6; // underrun/end of message
   localparam int BIT_CTS = 5; // clear to send
   localparam int BIT_SYNC = 4; // sync/hunt
   localparam int BIT_DCD = 3; // carrier detect
   localparam int BIT_TXE = 2; // transmit buffer empty
   localparam int BIT_ZERO = 1; // baud counter zero
   localparam int BIT_RXA = 0; // receive character available
   localparam logic [7:0] SRC_EN_RESET = 8'hf8; // bits 7..3 set
   localparam logic [7:0] SRC_EN_MASK = 8'hfa; // bits 2 and 0 unused
   // ----------------------------------------------------------------
   // control register fields
   // ----------------------------------------------------------------
   localparam int CTL_GROUP_EN = 0; // ext/status group enable
   localparam int CTL_MODE_LO = 1; // two-bit mode field
   localparam int CTL_CRYSTAL_OSCILLATOR_OPTION = 3; // crystal oscillator option
   localparam int CTL_TX_EN = 4; // transmitter enable
   localparam int CTL_RX_EN = 5; // receiver enable
   localparam logic [7:0] CTRL_RESET = 8'h00; // all off, async
   // ----------------------------------------------------------------
   // command bits
   // ----------------------------------------------------------------
   localparam int CMD_RESET_EXT = 0; // release pending latch
   localparam int CMD_RESET_EOM = 1; // clear underrun/eom latch
   localparam int CMD_SEND_ABORT = 2; // send abort
   localparam int CMD_ENTER_HUNT = 3; // enter hunt mode
   localparam int CMD_CHAN_RESET = 4; // channel reset
   // ----------------------------------------------------------------
   // counts
   // ----------------------------------------------------------------
   localparam int ABORT_ONES = 7; // ones that make an abort
   localparam int RX_DEPTH = 3; // receive fifo characters
   typedef enum logic [1:0] {
      MODE_ASYNC = 2'b00,
      MODE_BYTE_SYNC = 2'b01,
      MODE_FRAME = 2'b10,
      MODE_EXT_SYNC = 2'b11
   } mode_type;
endpackage : ext_status_pkg

// ---- hdl/ext_status_latch.sv ----
`timescale 1ns/100ps
module ext_status_latch (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic live_in,
   input wire logic enable_in,
   input wire logic pending_in,
   output logic status_out,
   output logic event_out
);
   // ----------------------------------------------------------------
   // held copy of one source
   // ----------------------------------------------------------------
   logic held_q; // last value seen while free

   // track the source while disabled or not pending
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         held_q <= live_in;
      end else if (!pending_in || !enable_in) begin
         held_q <= live_in;
      end
   end

   // difference after release covers an odd count of edges
   assign event_out = enable_in & ~pending_in & (live_in ^ held_q);
   // disabled source reports the live pin
   assign status_out = enable_in ? held_q : live_in;
endmodule : ext_status_latch

// ---- tb/ext_status_partner.sv ----
`timescale 1ns/100ps
module ext_status_partner (
   input wire logic clk_in,
   input wire logic [2:0] lines_in,
   input wire logic sync_drive_in,
   input wire logic sync_oe_n_in,
   output logic cts_out,
   output logic carrier_detect_out,
   output logic sync_out
);
   logic [2:0] line_q = 3'h0; // modem and sync levels
   // lines move just after a clock edge
   always_ff @(posedge clk_in) begin
      line_q <= lines_in;
   end
   assign cts_out = line_q[0];
   assign carrier_detect_out = line_q[1];
   // pin level: the device drives it only in byte-sync mode
   assign sync_out = sync_oe_n_in ? line_q[2] : sync_drive_in;
endmodule : ext_status_partner

// ---- tb/tb_ext_status_interrupt_ctrl.sv ----
`timescale 1ns/100ps
module tb_ext_status_interrupt_ctrl;
   import ext_status_pkg::*;
   logic clk_in, rst_n_in, awvalid, wvalid, bready, arvalid, rready;
   logic [ADDR_W-1:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic awready, wready, bvalid, arready, rvalid, cts, dcd, syn, so, soe;
   logic [1:0] bresp, rresp;
   logic irq; // pending latch output
   logic [2:0] lines, m;
   logic [12:0] ev; // event pulses and levels
   int miscompares, tests_run, n, k;
   logic rxq[$]; // receive fifo model
   ext_status_interrupt_ctrl u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
      .wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid),
      .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
      .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
      .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
      .rvalid_out(rvalid), .rready_in(rready), .cts_in(cts),
      .carrier_detect_in(dcd), .sync_in(syn), .sync_out(so),
      .sync_oe_n_out(soe), .brg_zero_in(ev[9]), .rx_bit_valid_in(ev[10]),
      .rx_bit_in(ev[11]), .rx_null_fe_in(ev[0]), .rx_break_end_in(ev[1]),
      .sync_pattern_in(ev[2]), .flag_in(ev[3]), .rx_char_in(ev[4]),
      .rx_char_read_in(ev[5]), .tx_underrun_in(ev[6]), .tx_load_in(ev[7]),
      .tx_drain_in(ev[8]), .tx_crc_sending_in(ev[12]),
      .ext_status_int_out(irq));
   ext_status_partner u_far (.clk_in(clk_in), .lines_in(lines),
      .sync_drive_in(so), .sync_oe_n_in(soe), .cts_out(cts),
      .carrier_detect_out(dcd), .sync_out(syn));
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         $display("BAD %0t seen %h exp %h", $time, s, e);
         miscompares++;
      end
   endtask : chk
   task final_report(input int t);
      miscompares += t;
      if (miscompares == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   // one write, each channel released once taken; bready stays high
   task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1'b1; wvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 40);
      if (!bvalid) final_report(1);
      chk(bresp, RESP_OKAY);
   endtask : wr
   // one read, compared under a mask; rready stays high
   task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
           input logic [31:0] mk);
      araddr <= a; arvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         if (arvalid && arready) arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 40);
      if (!rvalid) final_report(1);
      chk(rdata & mk, e);
      chk(rresp, (a > ADDR_PEND) ? RESP_SLVERR : RESP_OKAY);
      if (a == ADDR_PEND) chk(irq, e);
   endtask : rd
   task pins(input logic [2:0] v);
      lines <= v; repeat (4) @(posedge clk_in);
   endtask : pins
   task pulse(input int i);
      ev[i] <= 1'b1; @(posedge clk_in); ev[i] <= 1'b0; @(posedge clk_in);
   endtask : pulse
   initial begin
      clk_in = 0;
      forever #12.5 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      final_report(1);
   end
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
      rst_n_in = 0; lines = 0; ev = 0; miscompares = 0; tests_run = 0;
      bready = 1'b1; rready = 1'b1; // answers always accepted
      k = $urandom(82166);
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      rd(ADDR_SRC_EN, SRC_EN_RESET, 32'hff);
      rd(ADDR_STATUS, 32'h44, 32'hff);
      rd(5'h14, 32'h0, 32'hffffffff);
      wr(ADDR_SRC_EN, SRC_EN_MASK);
      rd(ADDR_SRC_EN, SRC_EN_MASK, 32'hff);
      pins(3'b001); rd(ADDR_PEND, 32'h0, 32'h1);
      wr(ADDR_CTRL, 8'h01); wr(ADDR_SRC_EN, 8'hda); pins(3'b000);
      wr(ADDR_SRC_EN, 8'hfa); rd(ADDR_PEND, 32'h0, 32'h1);
      for (k = 0; k < 2; k++) begin
         m = k ? 3'b010 : 3'b001;
         pins(lines ^ m); rd(ADDR_PEND, 32'h1, 32'h1);
         pins(lines ^ m); pins(lines ^ m); wr(ADDR_CMD, 8'h01);
         rd(ADDR_PEND, 32'h0, 32'h1);
         pins(lines ^ m); pins(lines ^ m); wr(ADDR_CMD, 8'h01);
         rd(ADDR_PEND, 32'h1, 32'h1);
         wr(ADDR_CMD, 8'h01); rd(ADDR_PEND, 32'h0, 32'h1);
      end
      pulse(9); rd(ADDR_PEND, 32'h1, 32'h1);
      wr(ADDR_CMD, 8'h01); rd(ADDR_PEND, 32'h0, 32'h1);
      repeat (1 + $urandom % RX_DEPTH) begin
         pulse(4); rxq.push_back(1'b1);
      end
      while (rxq.size() != 0) begin
         rd(ADDR_STATUS, 32'h1, 32'h1);
         pulse(5); void'(rxq.pop_front());
      end
      rd(ADDR_STATUS, 32'h0, 32'h1);
      pulse(7); rd(ADDR_STATUS, 32'h0, 32'h4);
      pulse(8); rd(ADDR_STATUS, 32'h4, 32'h4);
      // byte sync: hunting, then a found pattern, then enter hunt
      wr(ADDR_CTRL, 8'h03); wr(ADDR_CMD, 8'h01);
      chk({so, soe}, 2'b10);
      pulse(2); chk({so, soe}, 2'b00);
      rd(ADDR_PEND, 32'h1, 32'h1); rd(ADDR_STATUS, 32'h0, 32'h10);
      wr(ADDR_CMD, 8'h09); rd(ADDR_STATUS, 32'h10, 32'h10);
      // external sync: pin high holds the bit clear and interrupts
      wr(ADDR_CTRL, 8'h07); wr(ADDR_CMD, 8'h01); pins(3'b111);
      rd(ADDR_STATUS, 32'h0, 32'h10); rd(ADDR_PEND, 32'h1, 32'h1);
      wr(ADDR_CTRL, 8'h09); rd(ADDR_STATUS, 32'h0, 32'h10);
      // transmitter on, latch cleared, send abort sets it again
      wr(ADDR_CTRL, 8'h19); wr(ADDR_CMD, 8'h03);
      rd(ADDR_STATUS, 32'h0, 32'h40);
      wr(ADDR_CMD, 8'h04); rd(ADDR_PEND, 32'h1, 32'h1);
      wr(ADDR_CMD, 8'h10); rd(ADDR_PEND, 32'h0, 32'h1);
      rd(ADDR_SRC_EN, SRC_EN_RESET, 32'hff);
      pulse(0); rd(ADDR_PEND, 32'h1, 32'h1);
      rd(ADDR_STATUS, 32'h80, 32'h80);
      final_report(0);
   end
endmodule : tb_ext_status_interrupt_ctrl
